//--- qac_adc_model.sv
// behavioural model of the four converters
`timescale 1ns/10ps
module qac_adc_model (
	output logic       rclk_out, // link clock copy
	output logic [3:0] lane_out  // bit 0 is lane one
);
	initial {rclk_out, lane_out} = 5'h05;
	// 24-bit msb-first run, clock idles low
	task automatic send(input logic [95:0] w);
		#7;
		for (int i = 23; i >= 0; i--) begin
			#160 rclk_out = 1'b1;
			// bit launched on the rising edge, stable through the low phase
			lane_out = {w[i], w[24+i], w[48+i], w[72+i]};
			#160 rclk_out = 1'b0;
		end
		#160 lane_out = ~lane_out;
	endtask
endmodule // qac_adc_model

//--- qac_capture.sv
// quad converter serial capture: sample, sort, widen, store, notify
//
// Overview of operation
// - a rising level on the returned clock arms capture, and the following low level takes data.
// - each capture reads all four data lanes at the same instant, one bit per lane.
// - interleaved lane bits are regrouped so each lane's bits sit side by side in its own word.
// - bits arrive most significant first, so the first bit ends in the top position.
// - after twenty-four captures a full sample for all four lanes is held.
// - every 24-bit sample is extended to a 32-bit word before it is stored.
// - each complete sample set becomes four word writes to consecutive buffer locations.
// - when the current buffer is completely filled, a processor event is raised.
// - capture never stops and moves on to the other buffer after each full one.
// - one configuration data line is driven to all four converters alike.
`timescale 1ns/10ps
module qac_capture (
	input  wire logic                             clk_in,                    // 25 MHz clock
	input  wire logic                             rst_n_in,                  // async reset
	input  wire logic                             returned_serial_clock_in,  // clock copy back
	input  wire logic                             converter_data_lane_one_in,   // lane 1 data
	input  wire logic                             converter_data_lane_two_in,   // lane 2 data
	input  wire logic                             converter_data_lane_three_in, // lane 3 data
	input  wire logic                             converter_data_lane_four_in,  // lane 4 data
	input  wire logic                             config_data_in,            // config bit
	output logic                                  config_data_line_out,      // shared config line
	output logic                                  mem_wr_en_out,             // word write strobe
	output logic      [qac_pkg::QAC_ADDR_W-1:0]   mem_wr_addr_out,           // word address
	output logic      [qac_pkg::QAC_WORD_W-1:0]   mem_wr_data_out,           // widened sample
	output logic                                  processor_event_path_out,  // buffer full pulse
	output logic                                  filled_buffer_out          // half just filled
);
	import qac_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		qac_phase_t            phase;
		logic [QAC_CNT_W-1:0]  bit_cnt;
		qac_lane_words_t       acc;
		qac_lane_words_t       hold;
		logic                  wr_busy;
		logic [1:0]            wr_lane;
		logic [QAC_ADDR_W-1:0] wr_addr;
		logic                  wr_en;
		logic [QAC_ADDR_W-1:0] wr_addr_out;
		logic [QAC_WORD_W-1:0] wr_data;
		logic                  evt;
		logic                  filled;
		logic                  cfg;
	} qac_state_t;

	// ----------------------------------------
	// reset contents
	// ----------------------------------------
	// accumulators and write position cleared
	localparam qac_state_t QAC_STATE_RST = '{
		phase       : QAC_ST_WAIT_HIGH,
		bit_cnt     : QAC_CNT_RST,
		acc         : '0,
		hold        : '0,
		wr_busy     : 1'b0,
		wr_lane     : 2'h0,
		wr_addr     : QAC_ADDR_RST,
		wr_en       : 1'b0,
		wr_addr_out : QAC_ADDR_RST,
		wr_data     : '0,
		evt         : 1'b0,
		filled      : 1'b0,
		cfg         : 1'b0
	};

	qac_state_t s_q;
	qac_state_t s_d;

	logic [QAC_SYNC_W-1:0] pins_raw;
	logic [QAC_SYNC_W-1:0] pins_sync;
	logic                  rclk_s;
	logic [QAC_LANES-1:0]  lanes_s;

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	assign pins_raw = {returned_serial_clock_in,
	                   converter_data_lane_four_in,
	                   converter_data_lane_three_in,
	                   converter_data_lane_two_in,
	                   converter_data_lane_one_in};

	qac_sync u_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.async_in (pins_raw),
		.sync_out (pins_sync)
	);

	assign rclk_s  = pins_sync[QAC_SYNC_W-1];
	assign lanes_s = pins_sync[QAC_LANES-1:0];

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// one capture shifted into every lane word
	function automatic qac_lane_words_t qac_shift_lanes(
		input qac_lane_words_t      words, // current lane words
		input logic [QAC_LANES-1:0] bits   // one bit per lane
	);
		qac_lane_words_t res;
		res = words;
		for (int i = 0; i < QAC_LANES; i++) begin
			// first bit climbs to the top
			res[i] = {words[i][QAC_SAMPLE_W-2:0], bits[i]};
		end
		return res;
	endfunction

	// last word of a buffer half
	function automatic logic qac_half_end(
		input logic [QAC_ADDR_W-1:0] addr // word address
	);
		return addr[QAC_OFS_W-1:0] == QAC_LAST_OFS;
	endfunction

	// address wraps from the top half to zero
	function automatic logic [QAC_ADDR_W-1:0] qac_next_addr(
		input logic [QAC_ADDR_W-1:0] addr // word address
	);
		return addr + 7'h01;
	endfunction

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		// ----------------------------------------
		// defaults and config line
		// ----------------------------------------
		s_d       = s_q;
		s_d.wr_en = 1'b0;
		s_d.evt   = 1'b0;
		s_d.cfg   = config_data_in;

		// ----------------------------------------
		// link phase and bit capture
		// ----------------------------------------
		// returned clock timing
		case (s_q.phase)
			QAC_ST_WAIT_HIGH: begin
				if (rclk_s) begin
					s_d.phase = QAC_ST_WAIT_LOW;
				end
			end
			QAC_ST_WAIT_LOW: begin
				if (!rclk_s) begin
					s_d.phase = QAC_ST_WAIT_HIGH;
					s_d.acc = qac_shift_lanes(s_q.acc, lanes_s);
					if (s_q.bit_cnt == QAC_LAST_BIT) begin
						s_d.bit_cnt = QAC_CNT_RST;
						s_d.hold    = s_d.acc;
						s_d.wr_busy = 1'b1;
						s_d.wr_lane = 2'h0;
					end else begin
						s_d.bit_cnt = s_q.bit_cnt + 5'h01;
					end
				end
			end
			default: begin
				s_d.phase = QAC_ST_WAIT_HIGH;
			end
		endcase

		// ----------------------------------------
		// word writer
		// ----------------------------------------
		// four consecutive word writes
		if (s_q.wr_busy) begin
			s_d.wr_en       = 1'b1;
			s_d.wr_addr_out = s_q.wr_addr;
			s_d.wr_data     = qac_widen(s_q.hold[s_q.wr_lane]);
			s_d.wr_addr     = qac_next_addr(s_q.wr_addr);
			s_d.wr_lane     = s_q.wr_lane + 2'h1;
			if (s_q.wr_lane == QAC_LAST_LANE) begin
				s_d.wr_busy = 1'b0;
			end
		end

		// ----------------------------------------
		// buffer event
		// ----------------------------------------
		// event with the last word of a half
		if (s_q.wr_busy && qac_half_end(s_q.wr_addr)) begin
			s_d.evt    = 1'b1;
			s_d.filled = s_q.wr_addr[QAC_ADDR_W-1];
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_q <= QAC_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign config_data_line_out     = s_q.cfg;
	assign mem_wr_en_out            = s_q.wr_en;
	assign mem_wr_addr_out          = s_q.wr_addr_out;
	assign mem_wr_data_out          = s_q.wr_data;
	assign processor_event_path_out = s_q.evt;
	assign filled_buffer_out        = s_q.filled;
endmodule // qac_capture

//--- qac_capture_monitor.sv
// checker for the capture block outputs
`timescale 1ns/10ps
module qac_capture_monitor (
	input wire logic        clk_in,                   // clock
	input wire logic        rst_n_in,                 // reset
	input wire logic        mem_wr_en_out,            // strobe
	input wire logic [6:0]  mem_wr_addr_out,          // address
	input wire logic [31:0] mem_wr_data_out,          // data
	input wire logic        processor_event_path_out, // event
	input wire logic        filled_buffer_out         // half
);
	wire logic we = mem_wr_en_out;
	wire logic ev = processor_event_path_out;
	wire logic [6:0] ad = mem_wr_addr_out;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_burst; we [*4] ##1 !we; endsequence
	a_wr_burst: assert property ($rose(we) |-> s_burst) else $error("burst");
	a_addr_inc: assert property (we && $past(we) |-> ad==$past(ad)+7'h01) else $error("step");
	a_set_align: assert property ($rose(we) |-> ad[1:0] == 2'h0) else $error("align");
	a_evt_last: assert property (ev |-> we && ad[5:0] == 6'h3f) else $error("early");
	a_evt_due: assert property (we && ad[5:0] == 6'h3f |-> ev) else $error("late");
	a_evt_once: assert property (ev |=> !ev) else $error("twice");
	a_half_flag: assert property (ev |-> filled_buffer_out == ad[6]) else $error("half");
	a_sign_ext: assert property (we |-> mem_wr_data_out[31:24] == {8{mem_wr_data_out[23]}})
		else $error("ext");
endmodule // qac_capture_monitor
bind qac_capture qac_capture_monitor u_mon (.clk_in, .rst_n_in, .mem_wr_en_out,
	.mem_wr_addr_out, .mem_wr_data_out, .processor_event_path_out, .filled_buffer_out);

//--- qac_pkg.sv
// shared constants and types for the quad converter capture block
package qac_pkg;
	// ----------------------------------------
	// link geometry
	// ----------------------------------------
	localparam int unsigned QAC_LANES      = 4;
	localparam int unsigned QAC_SAMPLE_W   = 24;
	localparam int unsigned QAC_WORD_W     = 32;
	localparam int unsigned QAC_CNT_W      = 5;
	localparam logic [4:0]  QAC_LAST_BIT   = 5'h17;
	localparam int unsigned QAC_SYNC_W     = 5;
	// ----------------------------------------
	// sample buffer layout (two halves, ping-pong)
	// ----------------------------------------
	localparam int unsigned QAC_BUF_WORDS  = 64;
	localparam int unsigned QAC_OFS_W      = 6;
	localparam int unsigned QAC_ADDR_W     = 7;
	localparam logic [5:0]  QAC_LAST_OFS   = 6'h3f;
	localparam logic [1:0]  QAC_LAST_LANE  = 2'h3;
	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [6:0]  QAC_ADDR_RST   = 7'h00;
	localparam logic [4:0]  QAC_CNT_RST    = 5'h00;

	typedef enum logic [1:0] {
		QAC_ST_WAIT_HIGH = 2'b00,
		QAC_ST_WAIT_LOW  = 2'b01
	} qac_phase_t;

	typedef logic [QAC_LANES-1:0][QAC_SAMPLE_W-1:0] qac_lane_words_t;

	// sign-extend a converter sample into a memory word
	function automatic logic [QAC_WORD_W-1:0] qac_widen(input logic [QAC_SAMPLE_W-1:0] s);
		qac_widen = {{(QAC_WORD_W - QAC_SAMPLE_W){s[QAC_SAMPLE_W-1]}}, s};
	endfunction
endpackage

//--- qac_sync.sv
// two-flop synchroniser for the returned clock and data lanes
`timescale 1ns/10ps
module qac_sync (
	input  wire logic                            clk_in,   // system clock
	input  wire logic                            rst_n_in, // async reset, active low
	input  wire logic [qac_pkg::QAC_SYNC_W-1:0]  async_in, // raw pin levels
	output logic      [qac_pkg::QAC_SYNC_W-1:0]  sync_out  // synchronised levels
);
	import qac_pkg::*;

	typedef struct packed {
		logic [QAC_SYNC_W-1:0] meta;
		logic [QAC_SYNC_W-1:0] stable;
	} qac_sync_state_t;

	qac_sync_state_t s_q;
	qac_sync_state_t s_d;

	always_comb begin
		s_d        = s_q;
		s_d.meta   = async_in;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign sync_out = s_q.stable;
endmodule // qac_sync

//--- test_qac_capture.sv
// self-checking bench for the capture block
`timescale 1ns/10ps
module test_qac_capture;
	logic clk_in = 1'b0, rst_n_in = 1'b0, config_data_in = 1'b0;
	logic rclk, cfg, we, ev, half;
	logic [3:0] ln;
	logic [6:0] ad, ea = 7'h00;
	logic [31:0] wd;
	int miscompares = 0, compares = 0;
	initial forever #20 clk_in = ~clk_in;
	qac_adc_model adc (.rclk_out(rclk), .lane_out(ln));
	qac_capture uut (.clk_in, .rst_n_in, .returned_serial_clock_in(rclk),
		.converter_data_lane_one_in(ln[0]), .converter_data_lane_two_in(ln[1]),
		.converter_data_lane_three_in(ln[2]), .converter_data_lane_four_in(ln[3]),
		.config_data_in, .config_data_line_out(cfg), .mem_wr_en_out(we),
		.mem_wr_addr_out(ad), .mem_wr_data_out(wd), .processor_event_path_out(ev),
		.filled_buffer_out(half));
	task automatic chk(input logic [31:0] got, exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic t_config;
		chk({we, ev, half, cfg, ad}, 11'h000);
		repeat (2) begin
			@(negedge clk_in) config_data_in = ~config_data_in;
			@(negedge clk_in) chk(cfg, config_data_in);
		end
	endtask
	task automatic t_set(input logic [95:0] v);
		int n = 0;
		fork
			adc.send(v);
			for (int t = 0; t < 400 && n < 4; t++) begin
				@(negedge clk_in);
				if (we === 1'b1) begin
					chk(ad, ea);
					chk(wd, {{8{v[95-24*n]}}, v[95-24*n -: 24]});
					chk(ev, ea[5:0] == 6'h3f);
					if (ev === 1'b1) chk(half, ea[6]);
					ea++;
					n++;
				end
			end
		join
		chk(n, 4);
		if (n != 4) print_verdict;
	endtask
	task automatic t_fill;
		for (int k = 0; k < 33; k++)
			t_set({24'h800000 | 24'(k), 24'h7fffff ^ 24'(k), 24'(k), 24'hf00000});
	endtask
	initial begin
		repeat (2) @(negedge clk_in);
		rst_n_in = 1'b1;
		repeat (2) @(negedge clk_in);
		t_config();
		t_set({24'h800000, 24'h7fffff, 24'h000001, 24'hfffffe});
		t_fill();
		print_verdict();
	end
endmodule // test_qac_capture
